// ===== rtl/timer_pair_serial.sv
// What this block does
// - Full-duplex serial, bit rate from timer A.
// - Send start bit, then two stop bits.
// - Eight bits sent; parity replaces eighth.
// - Transmit request pulse per sent character.
// - Parity on: bit 7 becomes error flag.
// - Receive request pulse per received character.
// - Two 8-bit counters, own 6-bit prescalers.
// - Prescaler A internal; B internal or external.
// - Prescalers divide by 1 to 64.
// - Count down per pulse, request at end; A's request only with serial off.
// - Start, stop, continue, restart from initial.
// - Single-pass stops; continuous mode reloads.
// - Counters readable undisturbed; prescalers write-only.
// - Timer B: clock divided by eight, or pin.
// - External input: clock, trigger, or gate.
// - Cascade feeds timer A output to B.
// - Timer pin shows A, B or clock.
// - Serial uses port 3 line 0 and 7.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`include "timer_pair_defs.svh"
module timer_pair_serial (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic timer_input_pin,
	input wire logic serial_in_pin,
	input wire logic port3_line7_data,
	output logic serial_out_pin,
	output logic timer_output_pin,
	output logic receive_char_request,
	output logic transmit_or_timer_a_request,
	output logic timer_b_request
);
	function automatic logic [6:0] pre_step(input logic [5:0] cur,
		input logic [5:0] div, input logic pulse);
		pre_step = {1'b0, cur};
		if (pulse && cur == `PRE_ONE)
			pre_step = {1'b1, div};
		else if (pulse)
			pre_step = {1'b0, cur - `PRE_ONE};
	endfunction

	// A loaded zero wraps through 8'hFF, so it yields 256 ticks.
	function automatic logic [8:0] cnt_step(input logic [7:0] cur,
		input logic [7:0] init, input logic cont, input logic tick);
		cnt_step = {1'b0, cur};
		if (tick && cur == `CNT_ONE)
			cnt_step = {1'b1, cont ? init : 8'h00};
		else if (tick)
			cnt_step = {1'b0, cur - `CNT_ONE};
	endfunction

	logic [7:0] tmode_q, tmode_d, pre_a_q, pre_a_d, pre_b_q, pre_b_d;
	logic [7:0] init_a_q, init_a_d, init_b_q, init_b_d;
	logic [7:0] scfg_q, scfg_d, rdata_q, rdata_d;
	timer_pair_pkg::timer_t counter_timer_a_q, counter_timer_a_d;
	timer_pair_pkg::timer_t counter_timer_b_q, counter_timer_b_d;
	logic [2:0] div_q, div_d;
	logic tin_q, trig_run_q, trig_run_d, timer_output_pin_a_q, timer_output_pin_a_d;
	logic timer_output_pin_b_q, timer_output_pin_b_d, iclk_q, iclk_d, timer_output_pin_pin_q, timer_output_pin_pin_d;
	timer_pair_pkg::tx_state_t tx_state_q, tx_state_d;
	logic [10:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_bit_q, tx_bit_d, tx_ovs_q, tx_ovs_d;
	logic out7_q, out7_d;
	timer_pair_pkg::rx_state_t rx_state_q, rx_state_d;
	logic [3:0] rx_ovs_q, rx_ovs_d;
	logic [2:0] rx_bit_q, rx_bit_d;
	logic [7:0] rx_sh_q, rx_sh_d, rx_buf_q, rx_buf_d;
	logic rx_req_q, txa_req_q, tb_req_q;
	logic ta_tc, tb_tc, tx_done, rx_done, rx_perr, div_tick;
	logic wr_tmode, wr_sdata, ser_en, parity_en, ld_a, ld_b;
	timer_pair_pkg::tin_mode_t tin_mode;

	assign ser_en = scfg_q[`SCFG_SER_EN];
	assign parity_en = scfg_q[`SCFG_PARITY];
	assign wr_tmode = reg_wr && reg_addr == `ADDR_TMODE;
	assign wr_sdata = reg_wr && reg_addr == `ADDR_SDATA;
	assign ld_a = wr_tmode && reg_wdata[`TM_LOAD_A];
	assign ld_b = wr_tmode && reg_wdata[`TM_LOAD_B];
	assign div_tick = div_q == `DIV_LAST;
	assign tin_mode = timer_pair_pkg::tin_mode_t'(
		tmode_q[`TM_IN_HI:`TM_IN_LO]);
	assign rx_perr = ~(^rx_sh_q);
	assign reg_rdata = rdata_q;
	assign serial_out_pin = out7_q;
	assign timer_output_pin = timer_output_pin_pin_q;
	assign receive_char_request = rx_req_q;
	assign transmit_or_timer_a_request = txa_req_q;
	assign timer_b_request = tb_req_q;

	// Register file. Load bits act once and are never stored.
	always_comb
	begin
		tmode_d = tmode_q;
		pre_a_d = pre_a_q;
		pre_b_d = pre_b_q;
		init_a_d = init_a_q;
		init_b_d = init_b_q;
		scfg_d = scfg_q;
		rdata_d = 8'h00;
		// A software write in the same cycle beats the hardware stop.
		if (ta_tc && !pre_a_q[`PRE_CONT])
			tmode_d[`TM_EN_A] = 1'b0;
		if (tb_tc && !pre_b_q[`PRE_CONT])
			tmode_d[`TM_EN_B] = 1'b0;
		if (reg_wr)
		begin
			case (reg_addr)
				`ADDR_TMODE: tmode_d = reg_wdata & `TM_LOAD_MASK;
				`ADDR_PRE_A: pre_a_d = reg_wdata;
				`ADDR_PRE_B: pre_b_d = reg_wdata;
				`ADDR_CNT_A: init_a_d = reg_wdata;
				`ADDR_CNT_B: init_b_d = reg_wdata;
				`ADDR_SCFG: scfg_d = reg_wdata & `SCFG_MASK;
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`ADDR_SDATA: rdata_d = rx_buf_q;
				`ADDR_TMODE: rdata_d = tmode_q;
				`ADDR_CNT_A: rdata_d = counter_timer_a_q.cnt;
				`ADDR_CNT_B: rdata_d = counter_timer_b_q.cnt;
				`ADDR_SCFG: rdata_d = scfg_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tmode_q <= 8'h00;
			pre_a_q <= 8'h00;
			pre_b_q <= 8'h00;
			init_a_q <= 8'h00;
			init_b_q <= 8'h00;
			scfg_q <= 8'h00;
			rdata_q <= 8'h00;
		end
		else
		begin
			tmode_q <= tmode_d;
			pre_a_q <= pre_a_d;
			pre_b_q <= pre_b_d;
			init_a_q <= init_a_d;
			init_b_q <= init_b_d;
			scfg_q <= scfg_d;
			rdata_q <= rdata_d;
		end
	end

	// Counter/timers, prescalers and the timer output pin.
	always_comb
	begin
		logic [6:0] pa;
		logic [6:0] pb;
		logic [8:0] ca;
		logic [8:0] cb;
		logic b_ext;
		logic trig_mode;
		logic tin_fall;
		logic pulse_b;
		pa = 7'h00;
		pb = 7'h00;
		ca = 9'h000;
		cb = 9'h000;
		b_ext = 1'b0;
		trig_mode = 1'b0;
		tin_fall = 1'b0;
		pulse_b = 1'b0;
		div_d = div_q + 3'h1;
		tin_fall = tin_q && !timer_input_pin;
		b_ext = !pre_b_q[`PRE_INTSRC];
		trig_mode = tin_mode == timer_pair_pkg::TIN_TRIG
			|| tin_mode == timer_pair_pkg::TIN_RETRIG;
		trig_run_d = trig_run_q;
		pa = pre_step(counter_timer_a_q.pre, pre_a_q[`PRE_DIV_HI:`PRE_DIV_LO],
			div_tick && tmode_q[`TM_EN_A]);
		ca = cnt_step(counter_timer_a_q.cnt, init_a_q, pre_a_q[`PRE_CONT],
			pa[6]);
		ta_tc = ca[8];
		if (scfg_q[`SCFG_CASCADE])
			pulse_b = ta_tc;
		else if (!b_ext)
			pulse_b = div_tick;
		else
		begin
			case (tin_mode)
				timer_pair_pkg::TIN_CLOCK: pulse_b = tin_fall;
				timer_pair_pkg::TIN_GATE: pulse_b = div_tick && timer_input_pin;
				default: pulse_b = div_tick && trig_run_q;
			endcase
		end
		pb = pre_step(counter_timer_b_q.pre, pre_b_q[`PRE_DIV_HI:`PRE_DIV_LO],
			pulse_b && tmode_q[`TM_EN_B]);
		cb = cnt_step(counter_timer_b_q.cnt, init_b_q, pre_b_q[`PRE_CONT],
			pb[6]);
		tb_tc = cb[8];
		counter_timer_a_d = {pa[5:0], ca[7:0]};
		counter_timer_b_d = {pb[5:0], cb[7:0]};
		if (tb_tc && !pre_b_q[`PRE_CONT])
			trig_run_d = 1'b0;
		// Retrigger reloads mid-count; plain trigger only starts when idle.
		if (b_ext && trig_mode && tin_fall && tmode_q[`TM_EN_B]
			&& (tin_mode == timer_pair_pkg::TIN_RETRIG || !trig_run_q))
		begin
			trig_run_d = 1'b1;
			counter_timer_b_d = {pre_b_q[`PRE_DIV_HI:`PRE_DIV_LO], init_b_q};
		end
		if (ld_a)
			counter_timer_a_d = {reg_wdata[`TM_EN_A] ? pre_a_q[`PRE_DIV_HI:
				`PRE_DIV_LO] : pre_a_q[`PRE_DIV_HI:`PRE_DIV_LO],
				init_a_q};
		if (ld_b)
			counter_timer_b_d = {pre_b_q[`PRE_DIV_HI:`PRE_DIV_LO],
				init_b_q};
		timer_output_pin_a_d = timer_output_pin_a_q ^ ta_tc;
		timer_output_pin_b_d = timer_output_pin_b_q ^ tb_tc;
		iclk_d = !iclk_q;
		case (timer_pair_pkg::timer_output_pin_sel_t'(tmode_q[`TM_OUT_HI:`TM_OUT_LO]))
			timer_pair_pkg::TIMER_OUTPUT_PIN_A: timer_output_pin_pin_d = timer_output_pin_a_q;
			timer_pair_pkg::TIMER_OUTPUT_PIN_B: timer_output_pin_pin_d = timer_output_pin_b_q;
			timer_pair_pkg::TIMER_OUTPUT_PIN_CLK: timer_output_pin_pin_d = iclk_q;
			default: timer_output_pin_pin_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			counter_timer_a_q <= '0;
			counter_timer_b_q <= '0;
			div_q <= 3'h0;
			tin_q <= 1'b0;
			trig_run_q <= 1'b0;
			timer_output_pin_a_q <= 1'b0;
			timer_output_pin_b_q <= 1'b0;
			iclk_q <= 1'b0;
			timer_output_pin_pin_q <= 1'b0;
		end
		else
		begin
			counter_timer_a_q <= counter_timer_a_d;
			counter_timer_b_q <= counter_timer_b_d;
			div_q <= div_d;
			tin_q <= timer_input_pin;
			trig_run_q <= trig_run_d;
			timer_output_pin_a_q <= timer_output_pin_a_d;
			timer_output_pin_b_q <= timer_output_pin_b_d;
			iclk_q <= iclk_d;
			timer_output_pin_pin_q <= timer_output_pin_pin_d;
		end
	end

	// Transmitter: 16 timer A ticks per bit. Writes while busy are dropped.
	always_comb
	begin
		tx_state_d = tx_state_q;
		tx_sh_d = tx_sh_q;
		tx_bit_d = tx_bit_q;
		tx_ovs_d = tx_ovs_q;
		tx_done = 1'b0;
		case (tx_state_q)
			timer_pair_pkg::TX_IDLE:
			begin
				tx_sh_d = `TX_IDLE_LINE;
				if (wr_sdata && ser_en)
				begin
					tx_state_d = timer_pair_pkg::TX_SHIFT;
					tx_sh_d = {2'b11, parity_en ? ~(^reg_wdata[6:0]) :
						reg_wdata[7], reg_wdata[6:0], 1'b0};
					tx_bit_d = 4'h0;
					tx_ovs_d = 4'h0;
				end
			end
			timer_pair_pkg::TX_SHIFT:
			begin
				if (ta_tc)
				begin
					tx_ovs_d = tx_ovs_q + 4'h1;
					if (tx_ovs_q == `OVS_LAST)
					begin
						tx_sh_d = {1'b1, tx_sh_q[10:1]};
						tx_bit_d = tx_bit_q + 4'h1;
						if (tx_bit_q == `TX_LAST_BIT)
						begin
							tx_state_d = timer_pair_pkg::TX_IDLE;
							tx_done = 1'b1;
						end
					end
				end
			end
			default: tx_state_d = timer_pair_pkg::TX_IDLE;
		endcase
		out7_d = ser_en ? tx_sh_q[0] : port3_line7_data;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_state_q <= timer_pair_pkg::TX_IDLE;
			tx_sh_q <= `TX_IDLE_LINE;
			tx_bit_q <= 4'h0;
			tx_ovs_q <= 4'h0;
			out7_q <= 1'b1;
		end
		else
		begin
			tx_state_q <= tx_state_d;
			tx_sh_q <= tx_sh_d;
			tx_bit_q <= tx_bit_d;
			tx_ovs_q <= tx_ovs_d;
			out7_q <= out7_d;
		end
	end

	// Receiver. The stop bit is timed but never sampled, so framing errors are not seen.
	always_comb
	begin
		rx_state_d = rx_state_q;
		rx_ovs_d = rx_ovs_q;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_buf_d = rx_buf_q;
		rx_done = 1'b0;
		case (rx_state_q)
			timer_pair_pkg::RX_IDLE:
				if (ser_en && !serial_in_pin)
				begin
					rx_state_d = timer_pair_pkg::RX_START;
					rx_ovs_d = 4'h0;
				end
			timer_pair_pkg::RX_START:
				if (ta_tc)
				begin
					rx_ovs_d = rx_ovs_q + 4'h1;
					if (rx_ovs_q == `OVS_HALF)
					begin
						rx_ovs_d = 4'h0;
						rx_bit_d = 3'h0;
						rx_state_d = serial_in_pin ? timer_pair_pkg::RX_IDLE :
							timer_pair_pkg::RX_DATA;
					end
				end
			timer_pair_pkg::RX_DATA:
				if (ta_tc)
				begin
					rx_ovs_d = rx_ovs_q + 4'h1;
					if (rx_ovs_q == `OVS_LAST)
					begin
						rx_sh_d = {serial_in_pin, rx_sh_q[7:1]};
						rx_bit_d = rx_bit_q + 3'h1;
						if (rx_bit_q == `RX_LAST_BIT)
							rx_state_d = timer_pair_pkg::RX_STOP;
					end
				end
			default:
				if (ta_tc)
				begin
					rx_ovs_d = rx_ovs_q + 4'h1;
					if (rx_ovs_q == `OVS_LAST)
					begin
						rx_state_d = timer_pair_pkg::RX_IDLE;
						rx_done = 1'b1;
						rx_buf_d = parity_en ? {rx_perr, rx_sh_q[6:0]} :
							rx_sh_q;
					end
				end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_state_q <= timer_pair_pkg::RX_IDLE;
			rx_ovs_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_buf_q <= 8'h00;
			rx_req_q <= 1'b0;
			txa_req_q <= 1'b0;
			tb_req_q <= 1'b0;
		end
		else
		begin
			rx_state_q <= rx_state_d;
			rx_ovs_q <= rx_ovs_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
			rx_buf_q <= rx_buf_d;
			rx_req_q <= rx_done;
			txa_req_q <= ser_en ? tx_done : ta_tc;
			tb_req_q <= tb_tc;
		end
	end

	default clocking assert_cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence tx_launch;
		$rose(tx_state_q == timer_pair_pkg::TX_SHIFT) && ser_en;
	endsequence
	sequence rx_finish;
		rx_done ##1 receive_char_request;
	endsequence

	tx_start_bit_a: assert property (tx_launch |=> !serial_out_pin)
		else $error("start bit not low");
	tx_stop_bits_a: assert property (
		tx_state_q == timer_pair_pkg::TX_SHIFT && tx_bit_q >= 4'h9
		|-> tx_sh_q[0])
		else $error("stop bit not high");
	tx_odd_parity_a: assert property (
		(tx_launch and parity_en) |-> ^tx_sh_q[8:1])
		else $error("parity not odd");
	tx_done_irq_a: assert property (
		tx_done && ser_en |=> transmit_or_timer_a_request)
		else $error("no transmit request");
	rx_irq_pulse_a: assert property (
		rx_finish |=> !receive_char_request)
		else $error("receive request not a pulse");
	rx_parity_flag_a: assert property (
		rx_done && parity_en |=> rx_buf_q[7] == $past(rx_perr))
		else $error("parity flag wrong");
	cont_reload_a: assert property (
		ta_tc && pre_a_q[`PRE_CONT] && !ld_a
		|=> counter_timer_a_q.cnt == $past(init_a_q))
		else $error("no reload");
	// A mode write right after the stop may legally re-enable the counter.
	single_stop_a: assert property (
		ta_tc && !pre_a_q[`PRE_CONT] && !wr_tmode
		|=> !tmode_q[`TM_EN_A] ##1 (!tmode_q[`TM_EN_A] || $past(wr_tmode)))
		else $error("single pass did not stop");
	read_count_a: assert property (
		reg_rd && reg_addr == `ADDR_CNT_A
		|=> reg_rdata == $past(counter_timer_a_q.cnt))
		else $error("count read wrong");
	zero_is_256_a: assert property (
		counter_timer_a_q.cnt == 8'h00 && !ld_a
		&& counter_timer_a_q.pre == `PRE_ONE && div_tick && tmode_q[`TM_EN_A]
		|-> !ta_tc ##1 counter_timer_a_q.cnt == 8'hFF)
		else $error("zero not 256");
	timer_b_irq_a: assert property (tb_tc |=> timer_b_request)
		else $error("no timer b request");
endmodule

// ===== shared/timer_pair_defs.svh
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH
`define ADDR_SDATA 8'hF0
`define ADDR_TMODE 8'hF1
`define ADDR_CNT_B 8'hF2
`define ADDR_PRE_B 8'hF3
`define ADDR_CNT_A 8'hF4
`define ADDR_PRE_A 8'hF5
`define ADDR_SCFG 8'hF7
`define TM_LOAD_A 0
`define TM_EN_A 1
`define TM_LOAD_B 2
`define TM_EN_B 3
`define TM_OUT_HI 5
`define TM_OUT_LO 4
`define TM_IN_HI 7
`define TM_IN_LO 6
`define PRE_CONT 0
`define PRE_INTSRC 1
`define PRE_DIV_HI 7
`define PRE_DIV_LO 2
`define SCFG_SER_EN 0
`define SCFG_PARITY 1
`define SCFG_CASCADE 2
`define SCFG_MASK 8'h07
`define TM_LOAD_MASK 8'hFA
`define DIV_LAST 3'h7
`define PRE_ONE 6'h01
`define CNT_ONE 8'h01
`define OVS_LAST 4'hF
`define OVS_HALF 4'h7
`define TX_LAST_BIT 4'hA
`define RX_LAST_BIT 3'h7
`define TX_IDLE_LINE 11'h7FF
`endif

// ===== shared/timer_pair_pkg.sv
package timer_pair_pkg;
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;
	typedef enum logic [1:0] {
		TIMER_OUTPUT_PIN_OFF = 2'b00,
		TIMER_OUTPUT_PIN_A = 2'b01,
		TIMER_OUTPUT_PIN_B = 2'b10,
		TIMER_OUTPUT_PIN_CLK = 2'b11
	} timer_output_pin_sel_t;
	typedef enum logic [1:0] {
		TIN_CLOCK = 2'b00,
		TIN_GATE = 2'b01,
		TIN_TRIG = 2'b10,
		TIN_RETRIG = 2'b11
	} tin_mode_t;
	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] cnt;
	} timer_t;
endpackage

// ===== testbench/serial_peer.sv
`timescale 1ns/10ps
// Remote asynchronous peer. It sends a single stop bit, the least the block
// must accept, so that a receiver expecting two would be caught out.
module serial_peer #(
	parameter int BIT_CLK = 128
) (
	input wire logic clk,
	input wire logic en,
	input wire logic line_in,
	output logic line_out,
	input wire logic go,
	input wire logic [7:0] tx_byte,
	output logic got,
	output logic [7:0] rx_byte,
	output logic rx_ok
);
	logic [7:0] tx_hold;
	logic [7:0] rx_tmp;
	logic ok;
	initial
	begin
		line_out = 1'b1;
		forever
		begin
			@(posedge clk);
			if (go === 1'b1)
			begin
				tx_hold = tx_byte;
				line_out <= 1'b0;
				for (int i = 0; i < 9; i++)
				begin
					repeat (BIT_CLK) @(posedge clk);
					line_out <= (i < 8) ? tx_hold[i] : 1'b1;
				end
				repeat (BIT_CLK) @(posedge clk);
			end
		end
	end
	initial
	begin
		got = 1'b0;
		rx_byte = 8'h00;
		rx_ok = 1'b0;
		forever
		begin
			@(posedge clk);
			if (en === 1'b1 && line_in === 1'b0)
			begin
				repeat (BIT_CLK / 2) @(posedge clk);
				ok = (line_in === 1'b0);
				for (int i = 0; i < 10; i++)
				begin
					repeat (BIT_CLK) @(posedge clk);
					if (i < 8)
						rx_tmp[i] = line_in;
					else
						ok = ok && (line_in === 1'b1);
				end
				rx_byte <= rx_tmp;
				rx_ok <= ok;
				got <= 1'b1;
				@(posedge clk);
				got <= 1'b0;
			end
		end
	end
endmodule

// ===== testbench/timer_pair_serial_tb.sv
`timescale 1ns/10ps
`include "timer_pair_defs.svh"
module timer_pair_serial_tb;
	localparam int LIMIT = 40000;
	logic clk, nrst, reg_wr, reg_rd, rd_q, t_in, p3_d, ser_in, ser_out;
	logic t_out, rx_req, ta_req, tb_req, p_en, p_go, p_got, p_ok, t;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, p_byte, p_rx, d, g, s;
	logic [7:0] exp_rd[$];
	logic [7:0] exp_tx[$];
	int n_errors, checks, cyc, n_a, n_b, n_rx, a_last, a_prev, b_last, b_prev;
	int a0, b0, r0, seed;

	timer_pair_serial u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .timer_input_pin(t_in), .serial_in_pin(ser_in),
		.port3_line7_data(p3_d), .serial_out_pin(ser_out),
		.timer_output_pin(t_out), .receive_char_request(rx_req),
		.transmit_or_timer_a_request(ta_req), .timer_b_request(tb_req));
	serial_peer #(.BIT_CLK(128)) u_peer (.clk(clk), .en(p_en),
		.line_in(ser_out), .line_out(ser_in), .go(p_go), .tx_byte(p_byte),
		.got(p_got), .rx_byte(p_rx), .rx_ok(p_ok));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask

	task wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_rd.push_back(v);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	function automatic int cnt_of(input int k);
		return (k == 0) ? n_a : (k == 1) ? n_b : n_rx;
	endfunction

	task automatic wait_for(input int k, input int target, input int lim);
		int w;
		w = 0;
		while (cnt_of(k) < target && w < lim)
		begin
			@(posedge clk);
			w++;
		end
		if (w >= lim)
		begin
			n_errors++;
			$display("MISMATCH at %0t: request never came", $time);
		end
	endtask

	task fall_in();
		repeat (8) @(posedge clk);
		t_in <= 1'b0;
		repeat (8) @(posedge clk);
		t_in <= 1'b1;
	endtask

	task done(input string name);
		$display("Test %s finished", name);
	endtask

	// Read data stand only in the cycle after the strobe, so the watcher
	// delays the strobe by one edge and samples exactly there.
	always @(posedge clk)
	begin
		cyc++;
		if (rd_q === 1'b1)
			chk(reg_rdata, exp_rd.pop_front());
		if (p_got === 1'b1)
		begin
			chk(p_rx, exp_tx.pop_front());
			chk(p_ok, 1'b1);
		end
		if (ta_req === 1'b1)
		begin
			n_a++;
			a_prev = a_last;
			a_last = cyc;
		end
		if (tb_req === 1'b1)
		begin
			n_b++;
			b_prev = b_last;
			b_last = cyc;
		end
		if (rx_req === 1'b1)
			n_rx++;
		rd_q <= reg_rd;
		if (cyc >= LIMIT)
		begin
			n_errors++;
			$display("MISMATCH at %0t: run did not finish in time", $time);
			wrap_up();
		end
	end

	initial
	begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		t_in = 1'b1;
		p3_d = 1'b1;
		p_en = 1'b0;
		p_go = 1'b0;
		p_byte = 8'h00;
		seed = $urandom(83885);
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(8'hF0 + 8'(i), 8'h00);
		wr(8'hF6, 8'h5A);
		rd(8'hF6, 8'h00);
		p3_d <= 1'b0;
		repeat (3) @(posedge clk);
		chk(ser_out, 1'b0);
		p3_d <= 1'b1;
		done("reset and map");
		wr(`ADDR_PRE_A, 8'h04);
		wr(`ADDR_CNT_A, 8'h03);
		wr(`ADDR_TMODE, 8'h13);
		wait_for(0, 1, 200);
		repeat (200) @(posedge clk);
		chk(n_a, 1);
		chk(t_out, 1'b1);
		rd(`ADDR_CNT_A, 8'h00);
		rd(`ADDR_TMODE, 8'h10);
		done("single pass");
		wr(`ADDR_PRE_A, 8'h05);
		wr(`ADDR_CNT_A, 8'h00);
		wr(`ADDR_TMODE, 8'h03);
		wait_for(0, 4, 8000);
		chk(a_last - a_prev, 2048);
		done("count of 256");
		wr(`ADDR_PRE_B, 8'h03);
		wr(`ADDR_CNT_B, 8'h01);
		wr(`ADDR_TMODE, 8'h0C);
		repeat (4) @(posedge clk);
		a0 = n_a;
		wait_for(1, 3, 2000);
		chk(b_last - b_prev, 512);
		chk(n_a, a0);
		done("prescaler of 64");
		wr(`ADDR_TMODE, 8'h00);
		wr(`ADDR_PRE_B, 8'h04);
		wr(`ADDR_CNT_B, 8'h03);
		wr(`ADDR_TMODE, 8'h0C);
		b0 = n_b;
		fall_in();
		fall_in();
		chk(n_b, b0);
		fall_in();
		repeat (6) @(posedge clk);
		chk(n_b, b0 + 1);
		fall_in();
		chk(n_b, b0 + 1);
		rd(`ADDR_CNT_B, 8'h00);
		done("external clock");
		wr(`ADDR_TMODE, 8'h30);
		repeat (4) @(posedge clk);
		t = t_out;
		@(posedge clk);
		chk(t_out, {~t});
		done("clock on pin");
		// Timer A ends every 16 clk; B counts three of those ends.
		wr(`ADDR_SCFG, 8'h04);
		wr(`ADDR_CNT_A, 8'h02);
		wr(`ADDR_PRE_B, 8'h07);
		wr(`ADDR_CNT_B, 8'h03);
		wr(`ADDR_TMODE, 8'h2F);
		b0 = n_b;
		wait_for(1, b0 + 2, 400);
		chk(b_last - b_prev, 48);
		t = t_out;
		wait_for(1, b0 + 3, 200);
		repeat (3) @(posedge clk);
		chk(t_out, {~t});
		done("cascade");
		wr(`ADDR_SCFG, 8'h00);
		wr(`ADDR_PRE_B, 8'h04);
		wr(`ADDR_CNT_B, 8'h02);
		wr(`ADDR_TMODE, 8'h8C);
		b0 = n_b;
		repeat (40) @(posedge clk);
		chk(n_b, b0);
		fall_in();
		repeat (30) @(posedge clk);
		chk(n_b, b0 + 1);
		t_in <= 1'b0;
		wr(`ADDR_TMODE, 8'h4C);
		b0 = n_b;
		repeat (40) @(posedge clk);
		chk(n_b, b0);
		chk(t_out, 1'b0);
		t_in <= 1'b1;
		repeat (30) @(posedge clk);
		chk(n_b, b0 + 1);
		done("trigger and gate");
		// Timer A ends every 8 clk, so one bit lasts 128 clk.
		wr(`ADDR_PRE_A, 8'h05);
		wr(`ADDR_CNT_A, 8'h01);
		wr(`ADDR_TMODE, 8'h03);
		wr(`ADDR_SCFG, 8'h01);
		p3_d <= 1'b0;
		repeat (4) @(posedge clk);
		chk(ser_out, 1'b1);
		p_en <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			d = 8'($urandom);
			g = {~^d[6:0], d[6:0]};
			s = (k == 0) ? d : (k == 1) ? g : g ^ 8'h80;
			wr(`ADDR_SCFG, (k == 0) ? 8'h01 : 8'h03);
			exp_tx.push_back((k == 0) ? d : g);
			@(posedge clk);
			p_byte <= s;
			p_go <= 1'b1;
			@(posedge clk);
			p_go <= 1'b0;
			a0 = n_a;
			r0 = n_rx;
			wr(`ADDR_SDATA, d);
			wait_for(0, a0 + 1, 4000);
			wait_for(2, r0 + 1, 4000);
			repeat (300) @(posedge clk);
			chk(n_a, a0 + 1);
			chk(n_rx, r0 + 1);
			rd(`ADDR_SDATA, (k == 0) ? s : {(k == 2), s[6:0]});
		end
		done("serial duplex");
		repeat (10) @(posedge clk);
		wrap_up();
	end
endmodule
